// >>> inc/ookcfg_pkg.sv
// constants, field layout and bandwidth table of the ook modem configuration block
package ookcfg_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] OOKCFG_IDX_FILT_BW = 8'h1c;
  localparam logic [7:0] OOKCFG_IDX_OSR = 8'h20;
  localparam logic [7:0] OOKCFG_IDX_OFFS_2 = 8'h21;
  localparam logic [7:0] OOKCFG_IDX_OFFS_1 = 8'h22;
  localparam logic [7:0] OOKCFG_IDX_OFFS_0 = 8'h23;
  localparam logic [7:0] OOKCFG_IDX_GAIN_1 = 8'h24;
  localparam logic [7:0] OOKCFG_IDX_GAIN_0 = 8'h25;
  localparam logic [7:0] OOKCFG_IDX_MOD_CTL_1 = 8'h70;
  localparam logic [7:0] OOKCFG_IDX_MOD_CTL_2 = 8'h71;
  localparam logic [7:0] OOKCFG_IDX_STATUS = 8'h72;

  // filter bandwidth register fields
  localparam int OOKCFG_SKIP_BIT = 7;
  localparam int OOKCFG_DEC_HI = 6;
  localparam int OOKCFG_DEC_LO = 4;
  localparam int OOKCFG_FSET_HI = 3;
  localparam int OOKCFG_FSET_LO = 0;
  // modulation control fields
  localparam int OOKCFG_MANCH_BIT = 1;
  localparam int OOKCFG_MODTYP_HI = 1;
  localparam int OOKCFG_MODTYP_LO = 0;
  localparam logic [1:0] OOKCFG_MODTYP_OOK = 2'h1;
  // oversampling / offset / gain split: 20h holds osr[10:3], 21h[7:5] osr[2:0]
  localparam int OOKCFG_OSR_LO_HI = 7;
  localparam int OOKCFG_OSR_LO_LO = 5;
  localparam int OOKCFG_OFFS_TOP_HI = 3;
  localparam int OOKCFG_GAIN_TOP_HI = 2;
  // status bits
  localparam int OOKCFG_ST_OOK = 0;
  localparam int OOKCFG_ST_BW_OK = 1;
  localparam int OOKCFG_ST_MANCH = 2;
  localparam int OOKCFG_ST_CODE_ERR = 3;

  // reset values: 1.2 kbps, 75.2 kHz filter, manchester off
  localparam logic [7:0] OOKCFG_RST_FILT_BW = 8'h41;
  localparam logic [7:0] OOKCFG_RST_OSR = 8'h1a;
  localparam logic [7:0] OOKCFG_RST_OFFS_2 = 8'h00;
  localparam logic [7:0] OOKCFG_RST_OFFS_1 = 8'h9d;
  localparam logic [7:0] OOKCFG_RST_OFFS_0 = 8'h49;
  localparam logic [7:0] OOKCFG_RST_GAIN_1 = 8'h01;
  localparam logic [7:0] OOKCFG_RST_GAIN_0 = 8'h3d;
  localparam logic [7:0] OOKCFG_RST_MOD_CTL_1 = 8'h00;
  localparam logic [7:0] OOKCFG_RST_MOD_CTL_2 = 8'h00;

  // axi responses
  localparam logic [1:0] OOKCFG_RESP_OKAY = 2'h0;
  localparam logic [1:0] OOKCFG_RESP_SLVERR = 2'h2;

  localparam int OOKCFG_BW_W = 13;
  typedef logic [OOKCFG_BW_W-1:0] ookcfg_bw_t;

  // channel filter bandwidth in units of 100 Hz, zero for a code with no setting
  function automatic ookcfg_bw_t ookcfg_bw(input logic skip, input logic [3:0] fset);
    ookcfg_bw = '0;
    if (!skip)
    begin
      case (fset)
        4'h1: ookcfg_bw = 13'h02f0;
        4'h2: ookcfg_bw = 13'h0340;
        4'h3: ookcfg_bw = 13'h0384;
        4'h4: ookcfg_bw = 13'h03b9;
        4'h5: ookcfg_bw = 13'h0461;
        4'h6: ookcfg_bw = 13'h04ff;
        4'h7: ookcfg_bw = 13'h0563;
        default: ookcfg_bw = '0;
      endcase
    end
    else
    begin
      case (fset)
        4'hf: ookcfg_bw = 13'h077b;
        4'h1: ookcfg_bw = 13'h08cb;
        4'h2: ookcfg_bw = 13'h09b8;
        4'h3: ookcfg_bw = 13'h0a85;
        4'h4: ookcfg_bw = 13'h0b21;
        4'h8: ookcfg_bw = 13'h0d1b;
        4'h9: ookcfg_bw = 13'h0e22;
        4'ha: ookcfg_bw = 13'h106a;
        4'hb: ookcfg_bw = 13'h124c;
        4'hc: ookcfg_bw = 13'h1444;
        4'hd: ookcfg_bw = 13'h168a;
        4'he: ookcfg_bw = 13'h183f;
        default: ookcfg_bw = '0;
      endcase
    end
  endfunction

endpackage

// >>> inc/ookcfg_chip_if.sv
// chip stream carrier between the configuration top and the manchester decoder
`timescale 1ns/100ps
interface ookcfg_chip_if;
  logic chip;
  logic chip_valid;
  logic manch_en;
  logic bit_val;
  logic bit_valid;
  logic code_err;
  modport dec (input chip, input chip_valid, input manch_en, output bit_val, output bit_valid, output code_err);
  modport src (output chip, output chip_valid, output manch_en, input bit_val, input bit_valid, input code_err);
endinterface

// >>> hw/ookcfg_manch.sv
// manchester decoder for the recovered ook chip stream
`timescale 1ns/100ps
module ookcfg_manch
  import ookcfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  ookcfg_chip_if.dec link
);

  logic half_q;
  logic first_q;
  logic bit_q;
  logic bit_valid_q;
  logic err_q;

  ////////////////////////////////////////////////////////////////////////
  // half-bit phase; restarts whenever decoding is switched off
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      half_q <= 1'b0;
    else if (!link.manch_en)
      half_q <= 1'b0;
    else if (link.chip_valid)
      half_q <= ~half_q;
  end

  // first chip of each pair is kept until its partner arrives
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      first_q <= 1'b0;
    else if (link.chip_valid && !half_q)
      first_q <= link.chip;
  end

  // decoded bit; plain chips pass straight through when coding is off
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bit_q <= 1'b0;
      bit_valid_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      bit_valid_q <= 1'b0;
      err_q <= 1'b0;
      if (link.chip_valid && !link.manch_en)
      begin
        bit_q <= link.chip;
        bit_valid_q <= 1'b1;
      end
      else if (link.chip_valid && half_q)
      begin
        bit_q <= first_q;
        bit_valid_q <= 1'b1;
        err_q <= (first_q == link.chip); // a pair without a transition is no symbol
      end
    end
  end

  assign link.bit_val = bit_q;
  assign link.bit_valid = bit_valid_q;
  assign link.code_err = err_q;

endmodule

// >>> hw/ookcfg_top.sv
// ook receive modem configuration registers with axi4-lite slave and chip decoding
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module ookcfg_top
  import ookcfg_pkg::*;
#(
  parameter int AXI_ADDR_W = 12
)
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RX_CHIP,
  input wire logic RX_CHIP_VALID,
  output logic RX_BIT,
  output logic RX_BIT_VALID,
  output logic MANCH_ERROR,
  output logic OOK_MODE,
  output logic MANCH_EN,
  output logic [2:0] DEC_EXP,
  output logic DIV_THREE_SKIP,
  output logic [3:0] FILTER_SET,
  output logic BW_VALID,
  output logic [OOKCFG_BW_W-1:0] BW_100HZ,
  output logic [10:0] CR_OVERSAMPLING,
  output logic [19:0] CR_NCO_OFFSET,
  output logic [10:0] CR_LOOP_GAIN
);

  // the highest index must be reachable as a word address
  if (AXI_ADDR_W < 10 || AXI_ADDR_W > 32)
  begin : g_addr_check
    $error("ookcfg_top: AXI_ADDR_W must lie in 10..32");
  end

  logic aw_full_q;
  logic [7:0] aw_idx_q;
  logic w_full_q;
  logic [7:0] w_data_q;
  logic w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [7:0] rdata_q;
  logic commit;
  logic ar_take;
  logic [7:0] ar_idx;
  logic hit_w;
  logic [7:0] rd_byte;
  logic rd_hit;

  logic [7:0] filt_bw_q;
  logic [7:0] osr_q;
  logic [7:0] offs_2_q;
  logic [7:0] offs_1_q;
  logic [7:0] offs_0_q;
  logic [7:0] gain_1_q;
  logic [7:0] gain_0_q;
  logic [7:0] mod_ctl_1_q;
  logic [7:0] mod_ctl_2_q;
  logic code_err_q;
  logic ook_mode;
  logic [OOKCFG_BW_W-1:0] bw_q;
  logic [7:0] status;

  ookcfg_chip_if chip_link ();

  ////////////////////////////////////////////////////////////////////////
  // write address and data are held independently, so either may arrive first
  assign S_AXI_AWREADY = ~aw_full_q;
  assign S_AXI_WREADY = ~w_full_q;
  assign commit = aw_full_q & w_full_q & ~bvalid_q;

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      aw_full_q <= 1'b0;
      aw_idx_q <= 8'h00;
    end
    else if (S_AXI_AWVALID && !aw_full_q)
    begin
      aw_full_q <= 1'b1;
      aw_idx_q <= S_AXI_AWADDR[9:2]; // upper address bits are ignored
    end
    else if (commit)
      aw_full_q <= 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end
    else if (S_AXI_WVALID && !w_full_q)
    begin
      w_full_q <= 1'b1;
      w_data_q <= S_AXI_WDATA[7:0];
      w_strb_q <= S_AXI_WSTRB[0];
    end
    else if (commit)
      w_full_q <= 1'b0;
  end

  // a gap in the map answers slverr; address bits above bit 9 are ignored and alias onto the map
  always_comb
  begin
    hit_w = 1'b0;
    case (aw_idx_q)
      OOKCFG_IDX_FILT_BW, OOKCFG_IDX_OSR, OOKCFG_IDX_OFFS_2, OOKCFG_IDX_OFFS_1,
      OOKCFG_IDX_OFFS_0, OOKCFG_IDX_GAIN_1, OOKCFG_IDX_GAIN_0, OOKCFG_IDX_MOD_CTL_1,
      OOKCFG_IDX_MOD_CTL_2, OOKCFG_IDX_STATUS: hit_w = 1'b1;
      default: hit_w = 1'b0;
    endcase
  end

  // write response, one per committed write
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= OOKCFG_RESP_OKAY;
    end
    else if (commit)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= hit_w ? OOKCFG_RESP_OKAY : OOKCFG_RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      bvalid_q <= 1'b0;
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  ////////////////////////////////////////////////////////////////////////
  // configuration bytes; only byte lane 0 carries data, the status byte is read only
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      filt_bw_q <= OOKCFG_RST_FILT_BW;
      osr_q <= OOKCFG_RST_OSR;
      offs_2_q <= OOKCFG_RST_OFFS_2;
      offs_1_q <= OOKCFG_RST_OFFS_1;
      offs_0_q <= OOKCFG_RST_OFFS_0;
      gain_1_q <= OOKCFG_RST_GAIN_1;
      gain_0_q <= OOKCFG_RST_GAIN_0;
      mod_ctl_1_q <= OOKCFG_RST_MOD_CTL_1;
      mod_ctl_2_q <= OOKCFG_RST_MOD_CTL_2;
    end
    else if (commit && w_strb_q)
    begin
      case (aw_idx_q)
        OOKCFG_IDX_FILT_BW: filt_bw_q <= w_data_q;
        OOKCFG_IDX_OSR: osr_q <= w_data_q;
        OOKCFG_IDX_OFFS_2: offs_2_q <= w_data_q;
        OOKCFG_IDX_OFFS_1: offs_1_q <= w_data_q;
        OOKCFG_IDX_OFFS_0: offs_0_q <= w_data_q;
        OOKCFG_IDX_GAIN_1: gain_1_q <= w_data_q;
        OOKCFG_IDX_GAIN_0: gain_0_q <= w_data_q;
        OOKCFG_IDX_MOD_CTL_1: mod_ctl_1_q <= w_data_q;
        OOKCFG_IDX_MOD_CTL_2: mod_ctl_2_q <= w_data_q;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fields handed to the demodulator and clock recovery loop
  assign ook_mode = (mod_ctl_2_q[OOKCFG_MODTYP_HI:OOKCFG_MODTYP_LO] == OOKCFG_MODTYP_OOK);
  assign OOK_MODE = ook_mode;
  assign MANCH_EN = mod_ctl_1_q[OOKCFG_MANCH_BIT];
  assign DEC_EXP = filt_bw_q[OOKCFG_DEC_HI:OOKCFG_DEC_LO];
  assign DIV_THREE_SKIP = filt_bw_q[OOKCFG_SKIP_BIT];
  assign FILTER_SET = filt_bw_q[OOKCFG_FSET_HI:OOKCFG_FSET_LO];
  assign CR_OVERSAMPLING = {osr_q, offs_2_q[OOKCFG_OSR_LO_HI:OOKCFG_OSR_LO_LO]};
  assign CR_NCO_OFFSET = {offs_2_q[OOKCFG_OFFS_TOP_HI:0], offs_1_q, offs_0_q};
  assign CR_LOOP_GAIN = {gain_1_q[OOKCFG_GAIN_TOP_HI:0], gain_0_q};

  // bandwidth is registered so the table decode never reaches a pin directly
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      bw_q <= '0;
    else
      bw_q <= ookcfg_bw(filt_bw_q[OOKCFG_SKIP_BIT], filt_bw_q[OOKCFG_FSET_HI:OOKCFG_FSET_LO]);
  end

  assign BW_100HZ = bw_q;
  assign BW_VALID = ook_mode && (bw_q != '0);

  ////////////////////////////////////////////////////////////////////////
  // chip stream only reaches the decoder while ook demodulation is selected
  assign chip_link.chip = RX_CHIP;
  assign chip_link.chip_valid = RX_CHIP_VALID & ook_mode;
  assign chip_link.manch_en = mod_ctl_1_q[OOKCFG_MANCH_BIT];

  ookcfg_manch u_manch
  (
    .clk_sys (CLK_SYS),
    .reset_n (RESET_N),
    .link (chip_link)
  );

  assign RX_BIT = chip_link.bit_val;
  assign RX_BIT_VALID = chip_link.bit_valid;
  assign MANCH_ERROR = chip_link.code_err;

  ////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, answered one edge after it is taken
  assign S_AXI_ARREADY = ~rvalid_q;
  assign ar_take = S_AXI_ARVALID & ~rvalid_q;
  assign ar_idx = S_AXI_ARADDR[9:2];

  assign status = {4'h0, code_err_q, mod_ctl_1_q[OOKCFG_MANCH_BIT], BW_VALID, ook_mode};

  always_comb
  begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (ar_idx)
      OOKCFG_IDX_FILT_BW: rd_byte = filt_bw_q;
      OOKCFG_IDX_OSR: rd_byte = osr_q;
      OOKCFG_IDX_OFFS_2: rd_byte = offs_2_q;
      OOKCFG_IDX_OFFS_1: rd_byte = offs_1_q;
      OOKCFG_IDX_OFFS_0: rd_byte = offs_0_q;
      OOKCFG_IDX_GAIN_1: rd_byte = gain_1_q;
      OOKCFG_IDX_GAIN_0: rd_byte = gain_0_q;
      OOKCFG_IDX_MOD_CTL_1: rd_byte = mod_ctl_1_q;
      OOKCFG_IDX_MOD_CTL_2: rd_byte = mod_ctl_2_q;
      OOKCFG_IDX_STATUS: rd_byte = status;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= OOKCFG_RESP_OKAY;
      rdata_q <= 8'h00;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? OOKCFG_RESP_OKAY : OOKCFG_RESP_SLVERR;
      rdata_q <= rd_byte;
    end
    else if (S_AXI_RREADY)
      rvalid_q <= 1'b0;
  end

  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = {24'h000000, rdata_q};

  // sticky coding error, cleared by reading status; a new error in that cycle wins
  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      code_err_q <= 1'b0;
    else if (chip_link.code_err)
      code_err_q <= 1'b1;
    else if (ar_take && ar_idx == OOKCFG_IDX_STATUS)
      code_err_q <= 1'b0;
  end

endmodule

// >>> tb/ookcfg_top_assertions.sv
// concurrent checks on the ports of the ook modem configuration top
`timescale 1ns/100ps
module ookcfg_chk
  import ookcfg_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic RX_CHIP,
  input wire logic RX_CHIP_VALID,
  input wire logic RX_BIT,
  input wire logic RX_BIT_VALID,
  input wire logic MANCH_ERROR,
  input wire logic OOK_MODE,
  input wire logic MANCH_EN,
  input wire logic [3:0] FILTER_SET,
  input wire logic DIV_THREE_SKIP,
  input wire logic BW_VALID,
  input wire logic [OOKCFG_BW_W-1:0] BW_100HZ,
  input wire logic [10:0] CR_OVERSAMPLING,
  input wire logic [19:0] CR_NCO_OFFSET,
  input wire logic [10:0] CR_LOOP_GAIN
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  ////////////////////////////////////////
  // chip path: bits only come from accepted chips
  chk_ook_gate:
    assert property (RX_BIT_VALID |-> $past(OOK_MODE) && $past(RX_CHIP_VALID))
    else $error("bit out without an accepted ook chip");
  chk_plain_bit:
    assert property (OOK_MODE && !MANCH_EN && RX_CHIP_VALID |=> RX_BIT_VALID && RX_BIT == $past(RX_CHIP))
    else $error("uncoded chip not passed through");
  chk_manch_pair:
    assert property (MANCH_ERROR |-> RX_BIT_VALID && $past(MANCH_EN) && $past(RX_CHIP) == RX_BIT)
    else $error("coding error without equal chip pair");
  // bandwidth decode follows the filter code one cycle later
  chk_bw_unlisted:
    assert property (FILTER_SET == 4'h0 |=> BW_100HZ == '0)
    else $error("code zero gave a bandwidth");
  chk_bw_valid:
    assert property (BW_VALID == (OOK_MODE && BW_100HZ != '0))
    else $error("bandwidth valid flag wrong");
  chk_bw_low_row:
    assert property (!DIV_THREE_SKIP && FILTER_SET == 4'h1 |=> BW_100HZ == 13'h02f0)
    else $error("narrowest bandwidth code decoded wrong");
  chk_bw_top_row:
    assert property (DIV_THREE_SKIP && FILTER_SET == 4'he |=> BW_100HZ == 13'h183f)
    else $error("widest bandwidth code decoded wrong");
  // recovery settings only move on a write commit
  chk_cfg_quiet:
    assert property (!$rose(S_AXI_BVALID) |-> $stable({CR_OVERSAMPLING, CR_NCO_OFFSET, CR_LOOP_GAIN}))
    else $error("recovery settings moved without a write");
  // bus handshakes
  chk_write_commit:
    assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID
                     |=> ##1 S_AXI_BVALID)
    else $error("write response late");
  chk_bresp_hold:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_read_answer:
    assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  chk_rdata_hold:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
endmodule

bind ookcfg_top ookcfg_chk i_chk (.*);

// >>> tb/testbench.sv
// self-checking bench for the ook modem configuration top
`timescale 1ns/100ps
module testbench
  import ookcfg_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic rx_chip = 1'b0, rx_chip_valid = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_bit, rx_bit_valid, manch_error;
  logic ook_mode, manch_en, skip, bw_valid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [2:0] dec_exp;
  logic [3:0] fset;
  logic [12:0] bw;
  logic [10:0] osr, gain;
  logic [19:0] nco;
  int miscompares = 0, cmp_count = 0, slow = 0;
  logic [7:0] regs[9] = '{8'h1c, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h70, 8'h71};

  ookcfg_top i_ookcfg_top (.CLK_SYS(clk_sys), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .RX_CHIP(rx_chip), .RX_CHIP_VALID(rx_chip_valid), .RX_BIT(rx_bit),
    .RX_BIT_VALID(rx_bit_valid), .MANCH_ERROR(manch_error), .OOK_MODE(ook_mode), .MANCH_EN(manch_en),
    .DEC_EXP(dec_exp), .DIV_THREE_SKIP(skip), .FILTER_SET(fset), .BW_VALID(bw_valid), .BW_100HZ(bw),
    .CR_OVERSAMPLING(osr), .CR_NCO_OFFSET(nco), .CR_LOOP_GAIN(gain));

  ////////////////////////////////////////
  // compare and count; four-state so an unknown never matches
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  // axi write: both channels offered together, each released when taken
  task automatic axw(input logic [7:0] ix, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= {2'h0, ix, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk_sys);
      aw = aw | (awvalid & awready);
      w = w | (wvalid & wready);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
    end
    repeat (slow) @(posedge clk_sys);
    bready <= 1'b1;
    do @(posedge clk_sys); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // axi read; slow keeps rready low so the answer has to stand
  task automatic axr(input logic [7:0] ix, output logic [31:0] v, output logic [1:0] rs);
    araddr <= {2'h0, ix, 2'h0};
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    repeat (slow) @(posedge clk_sys);
    rready <= 1'b1;
    do @(posedge clk_sys); while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // extra edge after a write lets the registered bandwidth land
  task automatic wr(input logic [7:0] ix, input logic [7:0] v, input logic [1:0] er);
    axw(ix, {24'h0, v}, r);
    chk("bresp", r, er);
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] ix, input logic [7:0] ev, input logic [1:0] er);
    axr(ix, d, r);
    chk("rdata", d, {24'h0, ev});
    chk("rresp", r, er);
  endtask

  // one chip strobe, then the edge at which its result shows
  task automatic send(input logic v);
    rx_chip <= v;
    rx_chip_valid <= 1'b1;
    @(posedge clk_sys);
    rx_chip_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] rv[9] = '{8'h41, 8'h1a, 8'h00, 8'h9d, 8'h49, 8'h01, 8'h3d, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++)
      rd(regs[i], rv[i], 2'h0);
    chk("osr", osr, 11'h0d0);
    chk("nco", nco, 20'h09d49);
    chk("gain", gain, 11'h13d);
    chk("bw", bw, 13'd752);
  endtask

  // 1.2 kbps, 620.7 kHz example row written field by field
  task automatic t_fields;
    logic [7:0] v[7] = '{8'hce, 8'h4e, 8'h20, 8'h34, 8'h6e, 8'h00, 8'h6b};
    for (int i = 0; i < 7; i++)
    begin
      wr(regs[i], v[i], 2'h0);
      rd(regs[i], v[i], 2'h0);
    end
    chk("dec_exp", dec_exp, 3'h4);
    chk("skip", skip, 1'b1);
    chk("fset", fset, 4'he);
    chk("osr", osr, 11'h271);
    chk("nco", nco, 20'h0346e);
    chk("gain", gain, 11'h06b);
  endtask

  // modulation codes 3 down to 1, then every bypass and filter code
  task automatic t_bw;
    int b0[16] = '{0, 752, 832, 900, 953, 1121, 1279, 1379, 0, 0, 0, 0, 0, 0, 0, 0};
    int b1[16] = '{0, 2251, 2488, 2693, 2849, 0, 0, 0, 3355, 3618, 4202, 4684, 5188, 5770, 6207, 1915};
    int e;
    for (int m = 3; m >= 1; m--)
    begin
      wr(8'h71, 8'(m), 2'h0);
      chk("ook_mode", ook_mode, m == 1);
    end
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 16; c++)
      begin
        wr(8'h1c, {s[0], 3'h0, c[3:0]}, 2'h0);
        e = s ? b1[c] : b0[c];
        chk("bw", bw, e);
        chk("bw_valid", bw_valid, e != 0);
      end
  endtask

  // unmapped place refused and a strobe-less write dropped while the master stalls its ready
  task automatic t_resp;
    slow = 2;
    wr(8'h30, 8'h5a, 2'h2);
    rd(8'h30, 8'h00, 2'h2);
    wstrb <= 4'h0;
    wr(8'h1c, 8'h00, 2'h0);
    wstrb <= 4'h1;
    rd(8'h1c, 8'h8f, 2'h0);
    slow = 0;
  endtask

  // raw chips, coded pairs with a bad pair, then chips outside ook
  task automatic t_chips;
    logic [1:0] p[3] = '{2'b10, 2'b01, 2'b11};
    for (int i = 0; i < 2; i++)
    begin
      send(i[0]);
      chk("bit_valid", rx_bit_valid, 1'b1);
      chk("bit", rx_bit, i[0]);
    end
    wr(8'h70, 8'h02, 2'h0);
    chk("manch_en", manch_en, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      send(p[i][1]);
      chk("bit_valid", rx_bit_valid, 1'b0);
      send(p[i][0]);
      chk("bit_valid", rx_bit_valid, 1'b1);
      chk("bit", rx_bit, p[i][1]);
      chk("manch_error", manch_error, p[i][1] == p[i][0]);
    end
    // status ignores writes; the sticky coding error clears on its first read
    wr(8'h72, 8'h00, 2'h0);
    rd(8'h72, 8'h0f, 2'h0);
    rd(8'h72, 8'h07, 2'h0);
    wr(8'h71, 8'h00, 2'h0);
    send(1'b1);
    chk("bit_valid", rx_bit_valid, 1'b0);
  endtask

  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////
  // clock, main sequence and watchdog
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_fields;
    t_bw;
    t_resp;
    t_chips;
    summarize;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    summarize;
  end
endmodule
